// File: hw/port_dir_edge_irq_defines.vh
// Register indices, field layouts and reset values for the port block
`ifndef PORT_DIR_EDGE_IRQ_DEFINES_VH
`define PORT_DIR_EDGE_IRQ_DEFINES_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_SERIAL_PORT_DATA 6'h18
`define IDX_SERIAL_PORT_INPUT_LEVEL 6'h19
`define IDX_SERIAL_PORT_DIRECTION 6'h1A
`define IDX_EDGE_IRQ_ENABLE_BITS 6'h1C
`define IDX_EDGE_POLARITY_SELECT 6'h1D
`define IDX_EDGE_FLAG_BITS 6'h1F

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define SER_PINS 4
`define EDGE_PINS 8
`define RST_SERIAL_PORT_DATA 4'h0
`define RST_SERIAL_PORT_DIRECTION 4'h0
`define RST_EDGE_IRQ_ENABLE_BITS 8'h00
`define RST_EDGE_POLARITY_SELECT 8'h00
`define RST_EDGE_FLAG_BITS 8'h00

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: hw/port_direction_edge_irq.v
// Serial port direction control and edge-interrupt port behind AXI4-Lite
// What this block does
// - Direction bit 1 output, 0 input, unclaimed pins
// - Enabled serial transmit forces its pin output
// - Enabled serial receive forces its pin input unless transmit also enabled
// - Disabled channel returns pin to direction bit
// - Readbacks may lag direction change three cycles
// - Enable bit 0 masks, 1 enables pin interrupt
// - Active edge on pin sets its flag
// - Polarity bit picks rising or falling edge
// - Writing one clears the edge flag
// - Writing zero leaves flag; zero means none pending
// - Interrupt while any enabled flag is set
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "port_dir_edge_irq_defines.vh"

module port_direction_edge_irq #(
  parameter ADDR_W = 8
) (
  input wire I_CLK,
  input wire I_RST_N,
  // AXI4-Lite slave
  input wire [ADDR_W-1:0] I_AWADDR,
  input wire I_AWVALID,
  output wire O_AWREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  input wire I_WVALID,
  output wire O_WREADY,
  output wire [1:0] O_BRESP,
  output wire O_BVALID,
  input wire I_BREADY,
  input wire [ADDR_W-1:0] I_ARADDR,
  input wire I_ARVALID,
  output wire O_ARREADY,
  output wire [31:0] O_RDATA,
  output wire [1:0] O_RRESP,
  output wire O_RVALID,
  input wire I_RREADY,
  // Serial port pins and serial channel claims
  input wire [`SER_PINS-1:0] I_SER_PIN_IN,
  output wire [`SER_PINS-1:0] O_SER_PIN_OUT,
  output wire [`SER_PINS-1:0] O_SER_PIN_OE,
  input wire [`SER_PINS-1:0] I_SER_TX_EN,
  input wire [`SER_PINS-1:0] I_SER_TX_DATA,
  input wire [`SER_PINS-1:0] I_SER_RX_EN,
  // Edge interrupt pins
  input wire [`EDGE_PINS-1:0] I_EDGE_PIN_IN,
  output wire O_IRQ
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg awready_reg;
  reg wready_reg;
  reg [5:0] waddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg arready_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;

  reg [`SER_PINS-1:0] serial_port_data_reg;
  reg [`SER_PINS-1:0] serial_port_direction_reg;
  reg [`EDGE_PINS-1:0] edge_irq_enable_bits_reg;
  reg [`EDGE_PINS-1:0] edge_polarity_select_reg;
  reg [`EDGE_PINS-1:0] edge_flag_bits_reg;
  reg [`EDGE_PINS-1:0] edge_flag_bits_next;

  reg [`SER_PINS-1:0] ser_meta_reg;
  reg [`SER_PINS-1:0] ser_sync_reg;
  reg [`EDGE_PINS-1:0] edge_meta_reg;
  reg [`EDGE_PINS-1:0] edge_sync_reg;
  reg [`EDGE_PINS-1:0] edge_prev_reg;

  reg [`SER_PINS-1:0] pin_out_reg;
  reg [`SER_PINS-1:0] pin_oe_reg;
  reg [`SER_PINS-1:0] pin_oe_next;
  reg [`SER_PINS-1:0] pin_out_next;
  reg irq_reg;

  reg [31:0] rd_mux;
  reg rd_hit;
  reg wr_hit;

  wire aw_hs = I_AWVALID & awready_reg;
  wire w_hs = I_WVALID & wready_reg;
  // Write executes once address and data are both held and no answer pends
  wire do_write = ~awready_reg & ~wready_reg & ~bvalid_reg;
  wire wr_byte0 = do_write & wstrb_reg[0];
  // Per-register write selects, high in the cycle the write executes
  wire wr_sel_data = wr_byte0 & (waddr_reg == `IDX_SERIAL_PORT_DATA);
  wire wr_sel_dir = wr_byte0 & (waddr_reg == `IDX_SERIAL_PORT_DIRECTION);
  wire wr_sel_en = wr_byte0 & (waddr_reg == `IDX_EDGE_IRQ_ENABLE_BITS);
  wire wr_sel_pol = wr_byte0 & (waddr_reg == `IDX_EDGE_POLARITY_SELECT);
  wire wr_sel_flag = wr_byte0 & (waddr_reg == `IDX_EDGE_FLAG_BITS);
  wire ar_hs = I_ARVALID & arready_reg;
  wire [5:0] raddr_idx = I_ARADDR[7:2];
  wire [`EDGE_PINS-1:0] edge_rise = edge_sync_reg & ~edge_prev_reg;
  wire [`EDGE_PINS-1:0] edge_fall = ~edge_sync_reg & edge_prev_reg;
  wire [`EDGE_PINS-1:0] edge_event;
  wire [`EDGE_PINS-1:0] flag_clear;

  // ----------------------------------------------------------------
  // Per-pin edge select and flag update
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `EDGE_PINS; g = g + 1) begin : edge_pin
      assign edge_event[g] = edge_polarity_select_reg[g] ? edge_rise[g] : edge_fall[g];
      assign flag_clear[g] = wr_sel_flag & wdata_reg[g];
      always @* begin
        // Set wins over a clear in the same cycle
        if (edge_event[g]) begin
          edge_flag_bits_next[g] = 1'b1;
        end else if (flag_clear[g]) begin
          edge_flag_bits_next[g] = 1'b0;
        end else begin
          edge_flag_bits_next[g] = edge_flag_bits_reg[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin direction and drive
  // ----------------------------------------------------------------
  always @* begin
    // Transmit claim wins over receive on a shared pin
    pin_oe_next = (serial_port_direction_reg & ~I_SER_RX_EN) | I_SER_TX_EN;
    pin_out_next = (I_SER_TX_EN & I_SER_TX_DATA) | (~I_SER_TX_EN & serial_port_data_reg);
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (raddr_idx)
      `IDX_SERIAL_PORT_DATA: begin
        // Output pins read the latch, input pins the synchronized level
        rd_mux[`SER_PINS-1:0] = (pin_oe_reg & serial_port_data_reg) | (~pin_oe_reg & ser_sync_reg);
      end
      `IDX_SERIAL_PORT_INPUT_LEVEL: begin
        rd_mux[`SER_PINS-1:0] = ser_sync_reg;
      end
      `IDX_SERIAL_PORT_DIRECTION: begin
        rd_mux[`SER_PINS-1:0] = serial_port_direction_reg;
      end
      `IDX_EDGE_IRQ_ENABLE_BITS: begin
        rd_mux[`EDGE_PINS-1:0] = edge_irq_enable_bits_reg;
      end
      `IDX_EDGE_POLARITY_SELECT: begin
        rd_mux[`EDGE_PINS-1:0] = edge_polarity_select_reg;
      end
      `IDX_EDGE_FLAG_BITS: begin
        rd_mux[`EDGE_PINS-1:0] = edge_flag_bits_reg;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @* begin
    case (waddr_reg)
      `IDX_SERIAL_PORT_DATA: wr_hit = 1'b1;
      `IDX_SERIAL_PORT_INPUT_LEVEL: wr_hit = 1'b1;
      `IDX_SERIAL_PORT_DIRECTION: wr_hit = 1'b1;
      `IDX_EDGE_IRQ_ENABLE_BITS: wr_hit = 1'b1;
      `IDX_EDGE_POLARITY_SELECT: wr_hit = 1'b1;
      `IDX_EDGE_FLAG_BITS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write and read channels
  // ----------------------------------------------------------------
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      waddr_reg <= 6'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `RESP_OKAY;
    end else begin
      if (aw_hs) begin
        awready_reg <= 1'b0;
        waddr_reg <= I_AWADDR[7:2];
      end
      if (w_hs) begin
        wready_reg <= 1'b0;
        wdata_reg <= I_WDATA;
        wstrb_reg <= I_WSTRB;
      end
      if (do_write) begin
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_reg & I_BREADY) begin
        bvalid_reg <= 1'b0;
      end
      if (ar_hs) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_reg & I_RREADY) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      serial_port_data_reg <= `RST_SERIAL_PORT_DATA;
      serial_port_direction_reg <= `RST_SERIAL_PORT_DIRECTION;
      edge_irq_enable_bits_reg <= `RST_EDGE_IRQ_ENABLE_BITS;
      edge_polarity_select_reg <= `RST_EDGE_POLARITY_SELECT;
    end else begin
      if (wr_sel_data) begin
        serial_port_data_reg <= wdata_reg[`SER_PINS-1:0];
      end
      if (wr_sel_dir) begin
        serial_port_direction_reg <= wdata_reg[`SER_PINS-1:0];
      end
      if (wr_sel_en) begin
        edge_irq_enable_bits_reg <= wdata_reg[`EDGE_PINS-1:0];
      end
      if (wr_sel_pol) begin
        edge_polarity_select_reg <= wdata_reg[`EDGE_PINS-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronizers
  // ----------------------------------------------------------------
  // The first stage is never read; it may still be settling
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ser_meta_reg <= 4'h0;
      ser_sync_reg <= 4'h0;
      edge_meta_reg <= 8'h00;
      edge_sync_reg <= 8'h00;
      edge_prev_reg <= 8'h00;
    end else begin
      ser_meta_reg <= I_SER_PIN_IN;
      ser_sync_reg <= ser_meta_reg;
      edge_meta_reg <= I_EDGE_PIN_IN;
      edge_sync_reg <= edge_meta_reg;
      edge_prev_reg <= edge_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // Flags, pin drive and interrupt
  // ----------------------------------------------------------------
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      edge_flag_bits_reg <= `RST_EDGE_FLAG_BITS;
      pin_out_reg <= 4'h0;
      pin_oe_reg <= 4'h0;
      irq_reg <= 1'b0;
    end else begin
      edge_flag_bits_reg <= edge_flag_bits_next;
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
      // Next flag value, so the request rises together with its flag
      irq_reg <= |(edge_flag_bits_next & edge_irq_enable_bits_reg);
    end
  end

  assign O_AWREADY = awready_reg;
  assign O_WREADY = wready_reg;
  assign O_BVALID = bvalid_reg;
  assign O_BRESP = bresp_reg;
  assign O_ARREADY = arready_reg;
  assign O_RVALID = rvalid_reg;
  assign O_RDATA = rdata_reg;
  assign O_RRESP = rresp_reg;
  assign O_SER_PIN_OUT = pin_out_reg;
  assign O_SER_PIN_OE = pin_oe_reg;
  assign O_IRQ = irq_reg;

endmodule

// File: test/port_props.sv
// Checker for pin direction, interrupt and read answer timing
`timescale 1ns/1ps
module port_props (
  input wire I_CLK,
  input wire I_RST_N,
  input wire [3:0] I_SER_TX_EN,
  input wire [3:0] I_SER_TX_DATA,
  input wire [3:0] I_SER_RX_EN,
  input wire [3:0] O_SER_PIN_OUT,
  input wire [3:0] O_SER_PIN_OE,
  input wire [7:0] I_EDGE_PIN_IN,
  input wire O_IRQ,
  input wire O_BVALID,
  input wire I_AWVALID,
  input wire O_AWREADY,
  input wire I_WVALID,
  input wire O_WREADY,
  input wire I_ARVALID,
  input wire O_ARREADY,
  input wire O_RVALID
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  AST_TX_OE: assert property (1 |=> (O_SER_PIN_OE & $past(I_SER_TX_EN)) == $past(I_SER_TX_EN))
    else $error("tx pin not output");
  AST_RX_IN: assert property (1 |=> (O_SER_PIN_OE & $past(I_SER_RX_EN & ~I_SER_TX_EN)) == 4'h0)
    else $error("rx pin not input");
  AST_TX_OUT: assert property (1 |=> (O_SER_PIN_OUT & $past(I_SER_TX_EN)) == $past(I_SER_TX_DATA & I_SER_TX_EN))
    else $error("tx data not on pin");
  AST_IRQ_FALL: assert property ($fell(O_IRQ) |-> O_BVALID || $past(O_BVALID))
    else $error("irq fell without write");
  AST_IRQ_RISE: assert property ($rose(O_IRQ) |-> O_BVALID || $past(O_BVALID) ||
    $past(I_EDGE_PIN_IN, 3) != $past(I_EDGE_PIN_IN, 4))
    else $error("irq rose without cause");
  AST_AR_TAKE: assert property (I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY)
    else $error("read not answered");
  AST_AR_BUSY: assert property (O_RVALID |-> !O_ARREADY)
    else $error("ar ready during answer");
  AST_B_LATE: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY && !O_BVALID |-> ##2 O_BVALID)
    else $error("write not answered");
endmodule
bind port_direction_edge_irq port_props props_u (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_SER_TX_EN(I_SER_TX_EN),
  .I_SER_TX_DATA(I_SER_TX_DATA), .I_SER_RX_EN(I_SER_RX_EN), .O_SER_PIN_OUT(O_SER_PIN_OUT),
  .O_SER_PIN_OE(O_SER_PIN_OE), .I_EDGE_PIN_IN(I_EDGE_PIN_IN), .O_IRQ(O_IRQ), .O_BVALID(O_BVALID),
  .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
  .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID));

// File: test/pin_partner.sv
// Model of the serial port pins and what drives them from outside
`timescale 1ns/1ps
module pin_partner (
  input wire [3:0] i_pin_out,
  input wire [3:0] i_pin_oe,
  input wire [3:0] i_ext_level,
  output wire [3:0] o_pin_level
);
  // Wire level: block drives where enabled, outside level elsewhere
  assign o_pin_level = (i_pin_out & i_pin_oe) | (i_ext_level & ~i_pin_oe);
endmodule

// File: test/port_direction_edge_irq_bench.sv
// Bench for the port direction and edge interrupt block
`timescale 1ns/1ps
`include "port_dir_edge_irq_defines.vh"
module port_direction_edge_irq_bench;
  localparam [7:0] a_dat = {`IDX_SERIAL_PORT_DATA, 2'b00};
  localparam [7:0] a_lvl = {`IDX_SERIAL_PORT_INPUT_LEVEL, 2'b00};
  localparam [7:0] a_dir = {`IDX_SERIAL_PORT_DIRECTION, 2'b00};
  localparam [7:0] a_en = {`IDX_EDGE_IRQ_ENABLE_BITS, 2'b00};
  localparam [7:0] a_pol = {`IDX_EDGE_POLARITY_SELECT, 2'b00};
  localparam [7:0] a_flg = {`IDX_EDGE_FLAG_BITS, 2'b00};
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00, idx, edge_pins = 8'h00;
  reg awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg [3:0] tx_en = 4'h0, tx_data = 4'h0, rx_en = 4'h0, ext_level = 4'h0;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] pin_out, pin_oe, pin_level;
  integer miscompares = 0, checks_done = 0;
  always #25 clk = ~clk;
  port_direction_edge_irq dut_u (.I_CLK(clk), .I_RST_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(1'b1), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(1'b1),
    .I_SER_PIN_IN(pin_level), .O_SER_PIN_OUT(pin_out), .O_SER_PIN_OE(pin_oe), .I_SER_TX_EN(tx_en),
    .I_SER_TX_DATA(tx_data), .I_SER_RX_EN(rx_en), .I_EDGE_PIN_IN(edge_pins), .O_IRQ(irq));
  pin_partner partner_u (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext_level(ext_level), .o_pin_level(pin_level));
  // ----------------------------------------------------------------
  // Compare, bus tasks and verdict
  // ----------------------------------------------------------------
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("ERROR %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
        @(posedge clk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      chk({30'h0, bresp}, {30'h0, er});
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] er);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      do begin
        @(posedge clk);
        if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, er});
    end
  endtask
  task finish_test;
    begin
      if (miscompares == 0 && checks_done > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clk);
    miscompares = miscompares + 1;
    finish_test;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, unmapped holes answer with an error
    for (idx = 8'h18; idx < 8'h20; idx = idx + 8'h01)
      rd({idx[5:0], 2'b00}, 32'h0, (idx == 8'h1B || idx == 8'h1E) ? `RESP_SLVERR : `RESP_OKAY);
    wr(8'h6C, 32'hFF, `RESP_SLVERR);
    wr(a_dir, 32'h5, `RESP_OKAY);
    rd(a_dir, 32'h5, `RESP_OKAY);
    repeat (2) @(posedge clk);
    chk({28'h0, pin_oe}, 32'h5);
    // Serial channels claim pins, transmit wins on a shared pin
    tx_en <= 4'h2;
    tx_data <= 4'h2;
    rx_en <= 4'h3;
    repeat (2) @(posedge clk);
    chk({28'h0, pin_oe}, 32'h6);
    chk({28'h0, pin_out & 4'h2}, 32'h2);
    tx_en <= 4'h0;
    rx_en <= 4'h0;
    repeat (2) @(posedge clk);
    chk({28'h0, pin_oe}, 32'h5);
    // Readback source follows direction, settles after a change
    ext_level <= 4'h3;
    wr(a_dat, 32'hA, `RESP_OKAY);
    repeat (3) @(posedge clk);
    rd(a_dat, 32'h2, `RESP_OKAY);
    rd(a_lvl, 32'h2, `RESP_OKAY);
    wr(a_dir, 32'hF, `RESP_OKAY);
    repeat (3) @(posedge clk);
    rd(a_dat, 32'hA, `RESP_OKAY);
    rd(a_lvl, 32'hA, `RESP_OKAY);
    // Edge flags, polarity, masking and clearing
    edge_pins <= 8'hF0;
    repeat (5) @(posedge clk);
    rd(a_flg, 32'h0, `RESP_OKAY);
    wr(a_pol, 32'h0F, `RESP_OKAY);
    edge_pins <= 8'h3C;
    repeat (5) @(posedge clk);
    rd(a_flg, 32'hCC, `RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wr(a_en, 32'h04, `RESP_OKAY);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(a_flg, 32'h33, `RESP_OKAY);
    rd(a_flg, 32'hCC, `RESP_OKAY);
    wr(a_flg, 32'h04, `RESP_OKAY);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(a_flg, 32'hC8, `RESP_OKAY);
    wr(a_flg, 32'hC8, `RESP_OKAY);
    rd(a_flg, 32'h0, `RESP_OKAY);
    finish_test;
  end
endmodule
